// ===== rtl/vss_pkg.sv
package vss_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned MASK_HOLD_US     = 15;
  localparam int unsigned MASK_HOLD_CYC    = MASK_HOLD_US * CLK_MHZ;
  localparam int unsigned STARTUP_DELAY_US = 1500;
  localparam int unsigned STARTUP_DELAY_CYC = STARTUP_DELAY_US * CLK_MHZ;
  localparam int unsigned BOOT_HOLD_US     = 200;
  localparam int unsigned BOOT_HOLD_CYC    = BOOT_HOLD_US * CLK_MHZ;
  // Step clock ~1.8 MHz: half period in core cycles, rounded down
  localparam int unsigned STEP_CLK_KHZ     = 1800;
  localparam int unsigned STEP_HALF_CYC    = (CLK_MHZ * 1000) / (2 * STEP_CLK_KHZ);
  localparam int unsigned SS_DIV_RESET     = 100;

  // ==========================================================
  // Reference codes (6.25 mV per LSB, 0 V at code 0)
  // ==========================================================
  localparam logic [7:0] BOOT_CODE  = 8'hAD; // 1.081 V = 173 LSB
  localparam logic [7:0] UV_EN_CODE = 8'h60; // 0.6 V = 96 LSB

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_REF    = 4'h8;
  localparam logic [3:0] REG_SSDIV  = 4'hC;
  localparam int unsigned CTRL_EN_BIT = 0;

  // Sequencer states
  typedef enum logic [5:0] {
    VSS_OFF   = 6'h01,
    VSS_DELAY = 6'h02,
    VSS_RAMP  = 6'h04,
    VSS_BOOT  = 6'h08,
    VSS_TGT   = 6'h10,
    VSS_RUN   = 6'h20
  } vss_state_t;

  // Protection and drive controls
  typedef struct packed {
    logic ov_en;
    logic uv_en;
    logic oc_boost;
    logic all_phases;
    logic ls_allow;
    logic ss_done;
  } vss_ctl_t;

endpackage

// ===== rtl/vss_top.sv
`timescale 1ns/10ps
// Behaviour
// - Mask OV and UV checks during transitions, plus 15 us after each ends.
// - Raise overcurrent limit to 150% during transitions and 15 us after.
// - Reference change while low-power indicator is low enables all N phases.
// - Sample code on step-clock rise; accept only if next fall agrees.
// - From next rising step edge, move reference one LSB per step cycle.
// - Ignore code changes during a transition; resume at next rising edge.
// - Internal step clock runs near 1.8 MHz.
// - Below supply threshold, stay off with all drivers off.
// - Supplied and enabled, start soft-start toward programmed voltage.
// - Enable low clears latched faults, drops done flag, keeps drivers off.
// - Start soft-start only with all supplies good and enable released.
// - Release done output when soft-start completes.
// - Overvoltage always active in soft-start; undervoltage only while reference is at or above 0.6 V.
// - Soft-start with all phases; shed phases only after done.
// - Wait about 1.5 ms before ramping reference.
// - Ramp reference with soft-start oscillator up to 1.081 V boot level.
// - Hold boot level 200 us reading code, then ramp to target.
// - Code below boot level ramps reference down from boot.
// - Soft-start stepping uses its own oscillator, independent of switching.
// - Control loop keeps low-side off until high-side starts switching or soft-start is done.
// - Overvoltage protection may still turn low-side on during start-up.
module vss_top (
  // Clock, reset, enable
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CE_I,
  // Wishbone slave
  input  wire logic       CYC_I,
  input  wire logic       STB_I,
  input  wire logic       WE_I,
  input  wire logic [3:0] ADR_I,
  input  wire logic [3:0] SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic            ACK_O,
  // Supplies and pins
  input  wire logic       SUPPLY_GOOD_I,
  input  wire logic       OUTPUT_ENABLE_PIN_I,
  input  wire logic       LOW_POWER_INDICATOR_N_I,
  input  wire logic [7:0] VOLTAGE_ID_CODE_I,
  input  wire logic       HS_SWITCHING_I,
  input  wire logic       OV_DETECT_I,
  input  wire logic       UV_DETECT_I,
  // Outputs
  output logic      [7:0] REF_CODE_O,
  output logic            OV_EN_O,
  output logic            UV_EN_O,
  output logic            OC_BOOST_O,
  output logic            ALL_PHASES_O,
  output logic            DRIVERS_EN_O,
  output logic            LS_CTRL_EN_O,
  output logic            LS_FORCE_O,
  output logic            FAULT_O,
  output logic            SS_DONE_OUT_O,
  output logic            SS_DONE_OE_N_O
);

  // ==========================================================
  // Registers
  // ==========================================================
  vss_pkg::vss_state_t st_r, st_nxt;
  logic [7:0]  ref_r;
  logic [7:0]  vid_s1_r, vid_s2_r, vid_hold_r, tgt_r;
  logic [7:0]  step_cnt_r;
  logic        step_clk_r;
  logic [7:0]  ss_cnt_r;
  logic [7:0]  ss_div_r;
  logic [17:0] tmr_r;
  logic [10:0] mask_cnt_r;
  logic        cand_r, dvid_r, fault_r, ctl_en_r, psi_dvid_r;
  vss_pkg::vss_ctl_t ctl_r;

  // ==========================================================
  // Decode
  // ==========================================================
  wire enabled   = SUPPLY_GOOD_I & OUTPUT_ENABLE_PIN_I & ctl_en_r;
  wire step_tick = CE_I & (step_cnt_r == 8'(vss_pkg::STEP_HALF_CYC - 1));
  wire step_rise = step_tick & ~step_clk_r;
  wire step_fall = step_tick & step_clk_r;
  wire ss_tick   = CE_I & (ss_cnt_r == ss_div_r);
  wire at_tgt    = (ref_r == tgt_r);
  wire wb_req    = CYC_I & STB_I & ~ACK_O;
  wire wb_wr     = wb_req & WE_I & SEL_I[0];
  wire tmr_done  = (tmr_r == 18'h0);
  wire mask_busy = dvid_r | (mask_cnt_r != 11'h0);

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (ADR_I)
      vss_pkg::REG_CTRL:   rd_mux = {31'h0, ctl_en_r};
      vss_pkg::REG_STATUS: rd_mux = {20'h0, fault_r, dvid_r, ctl_r, st_r[5], st_r[0],
                                     2'h0};
      vss_pkg::REG_REF:    rd_mux = {16'h0, tgt_r, ref_r};
      vss_pkg::REG_SSDIV:  rd_mux = {24'h0, ss_div_r};
      default:             rd_mux = 32'h0;
    endcase
  end

  // ==========================================================
  // Wishbone slave: ack one cycle after request
  // ==========================================================
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ACK_O    <= 1'b0;
      DAT_O    <= 32'h0;
      ctl_en_r <= 1'b1;
      ss_div_r <= 8'(vss_pkg::SS_DIV_RESET);
    end else if (CE_I) begin
      ACK_O <= wb_req;
      DAT_O <= wb_req ? rd_mux : 32'h0;
      if (wb_wr && ADR_I == vss_pkg::REG_CTRL)  ctl_en_r <= DAT_I[vss_pkg::CTRL_EN_BIT];
      if (wb_wr && ADR_I == vss_pkg::REG_SSDIV) ss_div_r <= DAT_I[7:0];
    end
  end

  // ==========================================================
  // Internal oscillators: free running dividers
  // ==========================================================
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      step_cnt_r <= 8'h0;
      step_clk_r <= 1'b0;
      ss_cnt_r   <= 8'h0;
    end else if (CE_I) begin
      step_cnt_r <= step_tick ? 8'h0 : step_cnt_r + 8'h1;
      if (step_tick) step_clk_r <= ~step_clk_r;
      ss_cnt_r   <= ss_tick ? 8'h0 : ss_cnt_r + 8'h1;
    end
  end

  // ==========================================================
  // Code input sync, two flops deep; the confirm is in the sequencer
  // ==========================================================
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      vid_s1_r <= 8'h0;
      vid_s2_r <= 8'h0;
    end else if (CE_I) begin
      vid_s1_r <= VOLTAGE_ID_CODE_I;
      vid_s2_r <= vid_s1_r;
    end
  end

  // ==========================================================
  // Sequencer next state
  // ==========================================================
  always_comb begin
    case (st_r)
      vss_pkg::VSS_OFF:   st_nxt = enabled ? vss_pkg::VSS_DELAY : vss_pkg::VSS_OFF;
      vss_pkg::VSS_DELAY: st_nxt = tmr_done ? vss_pkg::VSS_RAMP : vss_pkg::VSS_DELAY;
      vss_pkg::VSS_RAMP:  st_nxt = (ref_r == vss_pkg::BOOT_CODE) ? vss_pkg::VSS_BOOT
                                                                : vss_pkg::VSS_RAMP;
      vss_pkg::VSS_BOOT:  st_nxt = tmr_done ? vss_pkg::VSS_TGT : vss_pkg::VSS_BOOT;
      vss_pkg::VSS_TGT:   st_nxt = at_tgt ? vss_pkg::VSS_RUN : vss_pkg::VSS_TGT;
      vss_pkg::VSS_RUN:   st_nxt = vss_pkg::VSS_RUN;
      default:            st_nxt = vss_pkg::VSS_OFF;
    endcase
    if (!enabled) st_nxt = vss_pkg::VSS_OFF;
  end

  // Sequencer, reference and timers.
  // Dropping enable resets everything at once, including the latched fault.
  always_ff @(posedge CLK_I) begin
    if (RST_I || (CE_I && !enabled)) begin
      st_r       <= vss_pkg::VSS_OFF;
      ref_r      <= 8'h0;
      tgt_r      <= 8'h0;
      tmr_r      <= 18'(vss_pkg::STARTUP_DELAY_CYC - 1);
      cand_r     <= 1'b0;
      vid_hold_r <= 8'h0;
      dvid_r     <= 1'b0;
      fault_r    <= 1'b0;
      psi_dvid_r <= 1'b0;
    end else if (CE_I) begin
      st_r <= st_nxt;
      // Entering the delay reloads the long count, any other move the boot window
      if (st_r != st_nxt)
        tmr_r <= (st_nxt == vss_pkg::VSS_DELAY) ? 18'(vss_pkg::STARTUP_DELAY_CYC - 1)
                                               : 18'(vss_pkg::BOOT_HOLD_CYC - 1);
      else if (!tmr_done)
        tmr_r <= tmr_r - 18'h1;
      // Stop at the boot level even if a tick lands in the leaving cycle
      if (st_r == vss_pkg::VSS_RAMP && ss_tick && ref_r != vss_pkg::BOOT_CODE)
        ref_r <= ref_r + 8'h1;
      if (st_r == vss_pkg::VSS_BOOT)
        tgt_r <= vid_s2_r;
      if (st_r == vss_pkg::VSS_TGT && ss_tick && !at_tgt)
        ref_r <= (tgt_r > ref_r) ? ref_r + 8'h1 : ref_r - 8'h1;
      // Running: confirm on fall, step on rises
      if (st_r == vss_pkg::VSS_RUN) begin
        if (!dvid_r && step_rise) begin
          cand_r     <= (vid_s2_r != tgt_r);
          vid_hold_r <= vid_s2_r;
        end
        if (!dvid_r && step_fall && cand_r) begin
          cand_r <= 1'b0;
          if (vid_s2_r == vid_hold_r) begin
            tgt_r      <= vid_hold_r;
            dvid_r     <= 1'b1;
            psi_dvid_r <= ~LOW_POWER_INDICATOR_N_I;
          end
        end
        if (dvid_r && step_rise) begin
          if (at_tgt) begin
            dvid_r     <= 1'b0;
            psi_dvid_r <= 1'b0;
          end else
            ref_r <= (tgt_r > ref_r) ? ref_r + 8'h1 : ref_r - 8'h1;
        end
      end
      if ((OV_DETECT_I && ctl_r.ov_en) || (UV_DETECT_I && ctl_r.uv_en))
        fault_r <= 1'b1;
    end
  end

  // ==========================================================
  // Post-transition mask hold, 15 us
  // ==========================================================
  always_ff @(posedge CLK_I) begin
    if (RST_I) mask_cnt_r <= 11'h0;
    else if (CE_I) begin
      if (dvid_r) mask_cnt_r <= 11'(vss_pkg::MASK_HOLD_CYC);
      else if (mask_cnt_r != 11'h0) mask_cnt_r <= mask_cnt_r - 11'h1;
    end
  end

  // ==========================================================
  // Control outputs
  // ==========================================================
  always_ff @(posedge CLK_I) begin
    // All phases stay on out of reset so the pin never glitches low
    if (RST_I) ctl_r <= '{all_phases: 1'b1, default: 1'b0};
    else if (CE_I) begin
      ctl_r.ov_en      <= (st_r != vss_pkg::VSS_OFF) & ~mask_busy;
      ctl_r.uv_en      <= (st_r != vss_pkg::VSS_OFF) & ~mask_busy &
                          (ref_r >= vss_pkg::UV_EN_CODE);
      ctl_r.oc_boost   <= mask_busy;
      ctl_r.all_phases <= (st_r != vss_pkg::VSS_RUN) | psi_dvid_r |
                          LOW_POWER_INDICATOR_N_I;
      ctl_r.ls_allow   <= (st_r == vss_pkg::VSS_RUN) | ctl_r.ls_allow & enabled |
                          (st_r != vss_pkg::VSS_OFF) & HS_SWITCHING_I;
      ctl_r.ss_done    <= (st_r == vss_pkg::VSS_RUN);
    end
  end

  // Registered pin outputs
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REF_CODE_O     <= 8'h0;
      OV_EN_O        <= 1'b0;
      UV_EN_O        <= 1'b0;
      OC_BOOST_O     <= 1'b0;
      ALL_PHASES_O   <= 1'b1;
      DRIVERS_EN_O   <= 1'b0;
      LS_CTRL_EN_O   <= 1'b0;
      LS_FORCE_O     <= 1'b0;
      FAULT_O        <= 1'b0;
      SS_DONE_OUT_O  <= 1'b0;
      SS_DONE_OE_N_O <= 1'b0;
    end else if (CE_I) begin
      REF_CODE_O     <= ref_r;
      OV_EN_O        <= ctl_r.ov_en;
      UV_EN_O        <= ctl_r.uv_en;
      OC_BOOST_O     <= ctl_r.oc_boost;
      ALL_PHASES_O   <= ctl_r.all_phases;
      DRIVERS_EN_O   <= enabled & (st_r != vss_pkg::VSS_OFF) & ~fault_r;
      LS_CTRL_EN_O   <= ctl_r.ls_allow & ~fault_r;
      // Overvoltage may fire the low side regardless of start-up blanking
      LS_FORCE_O     <= fault_r & OV_DETECT_I | ctl_r.ov_en & OV_DETECT_I;
      FAULT_O        <= fault_r;
      SS_DONE_OUT_O  <= 1'b0;
      SS_DONE_OE_N_O <= ctl_r.ss_done;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_confirm;
    dvid_r == 1'b0 ##1 dvid_r == 1'b1;
  endsequence

  step_rate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    step_rise |=> !step_rise [*8]) else $error("step clock too fast");
  dvid_mask_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    dvid_r && CE_I |=> ##1 !ctl_r.ov_en && !ctl_r.uv_en) else $error("mask missing");
  oc_boost_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(dvid_r) && CE_I |=> ##1 ctl_r.oc_boost) else $error("boost ended early");
  confirm_fall_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_confirm |-> $past(step_fall)) else $error("accept off fall edge");
  step_one_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    dvid_r && $changed(ref_r) |-> (ref_r - $past(ref_r) == 8'h1) ||
                                  ($past(ref_r) - ref_r == 8'h1)) else $error("bad step");
  ignore_code_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    dvid_r && $stable(dvid_r) |-> $stable(tgt_r)) else $error("target moved");
  en_off_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && !OUTPUT_ENABLE_PIN_I |=> ##2 !DRIVERS_EN_O && !SS_DONE_OE_N_O)
    else $error("not off");
  uv_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    ctl_r.uv_en |-> $past(ref_r) >= vss_pkg::UV_EN_CODE) else $error("uv early");
  boot_top_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_r == vss_pkg::VSS_RAMP |-> ref_r <= vss_pkg::BOOT_CODE) else $error("boot passed");

  // ==========================================================
  // Start-up and protection checks
  // ==========================================================
  // Soft-start states, where the loop still blanks the low side
  sequence s_soft_start;
    CE_I && (st_r == vss_pkg::VSS_RAMP || st_r == vss_pkg::VSS_BOOT ||
             st_r == vss_pkg::VSS_TGT);
  endsequence

  // A quiet soft-start cycle: no switching seen yet and low side not yet allowed
  sequence s_ss_quiet;
    s_soft_start ##0 !HS_SWITCHING_I && !ctl_r.ls_allow;
  endsequence

  delay_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_r == vss_pkg::VSS_DELAY |-> ref_r == 8'h00) else $error("ramp before delay");
  ss_climb_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_r == vss_pkg::VSS_RAMP && $changed(ref_r) |-> ref_r == $past(ref_r) + 8'h01)
    else $error("soft-start not climbing");
  ls_blank_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_ss_quiet |=> !ctl_r.ls_allow) else $error("low side freed early");
  ov_in_ss_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_soft_start ##0 !mask_busy |=> ctl_r.ov_en) else $error("ov off in soft-start");
  boost_dvid_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    dvid_r && CE_I |=> ctl_r.oc_boost) else $error("no boost in transition");
  done_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && st_r != vss_pkg::VSS_RUN |=> !ctl_r.ss_done) else $error("done too soon");
  no_supply_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && !SUPPLY_GOOD_I |=> !DRIVERS_EN_O) else $error("drivers without supply");

endmodule

// ===== test/vss_vid_host.sv
`timescale 1ns/10ps
// ======
// Processor side: drives the identification code lines
// ======
module vss_vid_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Requested code and pacing
  input  wire logic [7:0]  want_i,
  input  wire logic [15:0] pace_i,
  // Code lines
  output logic      [7:0]  code_o
);
  logic [15:0] wait_r;
  // Walk one LSB per pace period when pace is nonzero, since a wide jump is stepped at full rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_o <= 8'h00;
      wait_r <= 16'h0000;
    end else if (code_o != want_i) begin
      if (pace_i == 16'h0000) begin
        code_o <= want_i; // Prompt jump
      end else if (wait_r >= pace_i) begin
        code_o <= (want_i > code_o) ? code_o + 8'h01 : code_o - 8'h01;
        wait_r <= 16'h0000;
      end else begin
        wait_r <= wait_r + 16'h0001;
      end
    end
  end
endmodule

// ===== test/vid_step_and_softstart_sequencer_bench.sv
`timescale 1ns/10ps
// ======
// Bench for the reference sequencer
// ======
module vid_step_and_softstart_sequencer_bench;
  // Pins and bench state
  logic        CLK_I = 1'b0, RST_I = 1'b1, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic [3:0]  ADR_I = 4'h0;
  logic [31:0] DAT_I = 32'h0, DAT_O, rd, lfsr = 32'h7500;
  logic        ACK_O, SUPPLY_GOOD_I = 1'b0, OUTPUT_ENABLE_PIN_I = 1'b0;
  logic        LOW_POWER_INDICATOR_N_I = 1'b1, HS_SWITCHING_I = 1'b0, OV_DETECT_I = 1'b0;
  logic        OV_EN_O, UV_EN_O, OC_BOOST_O, ALL_PHASES_O, DRIVERS_EN_O, LS_CTRL_EN_O;
  logic        LS_FORCE_O, FAULT_O, SS_DONE_OUT_O, SS_DONE_OE_N_O;
  logic [7:0]  VOLTAGE_ID_CODE_I, REF_CODE_O, last_ref = 8'h00, want = 8'h00, tgt, e;
  logic [15:0] pace = 16'h0000;
  logic [7:0]  exp_q[$];
  int          miscompares = 0, n_compared = 0, n;

  always #5 CLK_I = ~CLK_I;

  vss_top DUT (
    .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(1'b1), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(4'hF), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .SUPPLY_GOOD_I(SUPPLY_GOOD_I), .OUTPUT_ENABLE_PIN_I(OUTPUT_ENABLE_PIN_I),
    .LOW_POWER_INDICATOR_N_I(LOW_POWER_INDICATOR_N_I), .VOLTAGE_ID_CODE_I(VOLTAGE_ID_CODE_I),
    .HS_SWITCHING_I(HS_SWITCHING_I), .OV_DETECT_I(OV_DETECT_I), .UV_DETECT_I(1'b0),
    .REF_CODE_O(REF_CODE_O), .OV_EN_O(OV_EN_O), .UV_EN_O(UV_EN_O), .OC_BOOST_O(OC_BOOST_O),
    .ALL_PHASES_O(ALL_PHASES_O), .DRIVERS_EN_O(DRIVERS_EN_O), .LS_CTRL_EN_O(LS_CTRL_EN_O),
    .LS_FORCE_O(LS_FORCE_O), .FAULT_O(FAULT_O), .SS_DONE_OUT_O(SS_DONE_OUT_O),
    .SS_DONE_OE_N_O(SS_DONE_OE_N_O));

  vss_vid_host host (.clk_i(CLK_I), .rst_i(RST_I), .want_i(want), .pace_i(pace),
    .code_o(VOLTAGE_ID_CODE_I));

  // ======
  // Compare, report and bus tasks
  // ======
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    miscompares++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    wrap_up();
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= a;
    DAT_I <= d;
    do begin
      @(posedge CLK_I);
      k++;
      if (k > 50) give_up("bus ack");
    end while (ACK_O !== 1'b1);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  task automatic wait_ref(input logic [7:0] v, input int bound, output int cyc);
    cyc = 0;
    while (REF_CODE_O !== v) begin
      @(posedge CLK_I);
      cyc++;
      if (cyc > bound) give_up("reference wait");
    end
  endtask

  // Reference moves one LSB at a time, except the drop to zero on disable, so the model is a list
  task automatic push_ramp(input logic [7:0] a, input logic [7:0] b);
    while (a != b) begin
      a = (b > a) ? a + 8'h01 : a - 8'h01;
      exp_q.push_back(a);
    end
  endtask

  // Every move of the reference must be the next value the model holds
  always @(posedge CLK_I) begin
    if (!RST_I && REF_CODE_O !== last_ref) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hEE;
      chk_word("ref step", {24'h0, e}, {24'h0, REF_CODE_O});
      last_ref <= REF_CODE_O;
    end
  end

  // Watchdog against a hung run
  initial begin
    repeat (400000) @(posedge CLK_I);
    give_up("run");
  end

  // ======
  // Main sequence
  // ======
  initial begin
    repeat (8) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    chk_bit("phases", 1'b1, ALL_PHASES_O);
    wb(1'b0, vss_pkg::REG_CTRL, 32'h0);
    chk_word("ctrl", 32'h1, rd);
    wb(1'b0, vss_pkg::REG_SSDIV, 32'h0);
    chk_word("ssdiv", vss_pkg::SS_DIV_RESET, rd);
    wb(1'b0, 4'h2, 32'h0);
    chk_word("unmapped", 32'h0, rd);
    wb(1'b1, vss_pkg::REG_SSDIV, 32'h1); // Short soft-start tick
    SUPPLY_GOOD_I <= 1'b1;
    repeat (200) @(posedge CLK_I);
    chk_bit("drv pin low", 1'b0, DRIVERS_EN_O);
    chk_bit("done pin low", 1'b0, SS_DONE_OE_N_O);
    SUPPLY_GOOD_I <= 1'b0;
    OUTPUT_ENABLE_PIN_I <= 1'b1;
    repeat (200) @(posedge CLK_I);
    chk_bit("drv no supply", 1'b0, DRIVERS_EN_O);
    want <= 8'h90;
    LOW_POWER_INDICATOR_N_I <= 1'b0;
    SUPPLY_GOOD_I <= 1'b1;
    push_ramp(8'h00, vss_pkg::BOOT_CODE);
    push_ramp(vss_pkg::BOOT_CODE, 8'h90);
    repeat (vss_pkg::STARTUP_DELAY_CYC - 100) @(posedge CLK_I);
    chk_word("delay", 32'h0, {24'h0, REF_CODE_O});
    wait_ref(8'h01, 300, n);
    wait_ref(8'h40, 300, n);
    chk_bit("uv low ref", 1'b0, UV_EN_O);
    chk_bit("ov in ss", 1'b1, OV_EN_O);
    chk_bit("ls blank", 1'b0, LS_CTRL_EN_O);
    chk_bit("ss phases", 1'b1, ALL_PHASES_O);
    chk_bit("drv ss", 1'b1, DRIVERS_EN_O);
    wait_ref(vss_pkg::BOOT_CODE, 400, n);
    repeat (vss_pkg::BOOT_HOLD_CYC - 100) @(posedge CLK_I);
    chk_bit("uv boot", 1'b1, UV_EN_O);
    chk_word("boot hold", {24'h0, vss_pkg::BOOT_CODE}, {24'h0, REF_CODE_O});
    chk_bit("not done", 1'b0, SS_DONE_OE_N_O);
    wait_ref(8'h90, 400, n);
    HS_SWITCHING_I <= 1'b1;
    repeat (6) @(posedge CLK_I);
    chk_bit("done", 1'b1, SS_DONE_OE_N_O);
    chk_bit("done out", 1'b0, SS_DONE_OUT_O);
    chk_bit("ls on", 1'b1, LS_CTRL_EN_O);
    chk_bit("shed", 1'b0, ALL_PHASES_O);
    // Random dynamic change of two to five LSBs
    lfsr = lfsr_next(lfsr);
    tgt = 8'h92 + {6'h0, lfsr[1:0]};
    want <= tgt;
    push_ramp(8'h90, tgt);
    wait_ref(8'h91, 300, n);
    chk_bit("ov mask", 1'b0, OV_EN_O);
    chk_bit("uv mask", 1'b0, UV_EN_O);
    chk_bit("oc boost", 1'b1, OC_BOOST_O);
    chk_bit("dyn phases", 1'b1, ALL_PHASES_O);
    wait_ref(8'h92, 300, n);
    chk_word("step period", 2 * vss_pkg::STEP_HALF_CYC, n);
    wait_ref(tgt, 400, n);
    repeat (1400) @(posedge CLK_I);
    chk_bit("boost hold", 1'b1, OC_BOOST_O);
    chk_bit("mask hold", 1'b0, OV_EN_O);
    repeat (300) @(posedge CLK_I);
    chk_bit("boost end", 1'b0, OC_BOOST_O);
    chk_bit("ov back", 1'b1, OV_EN_O);
    chk_bit("uv back", 1'b1, UV_EN_O);
    // A change inside a transition waits for the next one
    push_ramp(tgt, tgt + 8'h06);
    want <= tgt + 8'h04;
    wait_ref(tgt + 8'h01, 300, n);
    want <= tgt + 8'h06;
    wait_ref(tgt + 8'h06, 1200, n);
    // Slow, paced descent from the processor side
    pace <= 16'd150;
    want <= tgt + 8'h03;
    push_ramp(tgt + 8'h06, tgt + 8'h03);
    wait_ref(tgt + 8'h03, 1500, n);
    repeat (1700) @(posedge CLK_I);
    exp_q.push_back(8'h00);
    OV_DETECT_I <= 1'b1;
    repeat (6) @(posedge CLK_I);
    chk_bit("fault", 1'b1, FAULT_O);
    chk_bit("ls force", 1'b1, LS_FORCE_O);
    OV_DETECT_I <= 1'b0;
    OUTPUT_ENABLE_PIN_I <= 1'b0;
    repeat (6) @(posedge CLK_I);
    chk_bit("fault clr", 1'b0, FAULT_O);
    chk_bit("done clr", 1'b0, SS_DONE_OE_N_O);
    chk_bit("drv off", 1'b0, DRIVERS_EN_O);
    wrap_up();
  end
endmodule
